// file: hw/par_pkg.sv
// Package with the register map, field positions and reset values of the negotiation registers.
`default_nettype none

package par_pkg;

	// ==========================================================================
	// Register byte offsets
	// ==========================================================================
	localparam logic [7:0] OFS_PARTNER_ABILITY = 8'hC8;
	localparam logic [7:0] OFS_EXPANSION       = 8'hCC;
	localparam logic [7:0] OFS_MODE_CONTROL    = 8'hD0;
	localparam logic [7:0] OFS_CONFIG_STATUS   = 8'hD4;
	localparam logic [7:0] OFS_IRQ_ENABLE      = 8'hD8;
	localparam logic [7:0] OFS_FAST_TX_CONTROL = 8'hDC;

	// ==========================================================================
	// Partner ability and expansion fields
	// ==========================================================================
	localparam int BIT_PARTNER_T4        = 9;
	localparam int BIT_PARTNER_FAST_FULL = 8;
	localparam int BIT_PARTNER_FAST_HALF = 7;
	localparam int BIT_PARTNER_TEN_FULL  = 6;
	localparam int BIT_PARTNER_TEN_HALF  = 5;
	localparam int SELECTOR_W            = 5;
	localparam logic [4:0] SELECTOR_IEEE = 5'h01;
	localparam int BIT_EXP_PDF           = 4;
	localparam int BIT_EXP_PARTNER_NP    = 3;
	localparam int BIT_EXP_OWN_NP        = 2;
	localparam int BIT_EXP_PAGE          = 1;
	localparam int BIT_EXP_PARTNER_AN    = 0;

	// ==========================================================================
	// Mode control, configuration, interrupt and fast control fields
	// ==========================================================================
	localparam int BIT_LONG_SQUELCH = 11;
	localparam int BIT_SPEED        = 9;
	localparam int BIT_DUPLEX       = 8;
	localparam int BIT_PAUSE        = 7;
	localparam int IRQ_W            = 7;
	localparam int BIT_IRQ_ANC      = 6;
	localparam int BIT_IRQ_RFAULT   = 5;
	localparam int BIT_IRQ_LINK     = 4;
	localparam int BIT_IRQ_ACK      = 3;
	localparam int BIT_IRQ_PDF      = 2;
	localparam int BIT_IRQ_PAGE     = 1;
	localparam int BIT_IRQ_RXERR    = 0;
	localparam int BIT_RXERR_OFF    = 13;
	localparam int BIT_FAST_ANC     = 12;

	// ==========================================================================
	// Reset values, counts and bus answers
	// ==========================================================================
	localparam logic [6:0] RST_IRQ_ENABLE = 7'h00;
	localparam logic       RST_SQUELCH    = 1'b0;
	localparam logic       RST_RXERR_OFF  = 1'b0;
	localparam int         RX_ERR_LIMIT   = 64;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage : par_pkg

`default_nettype wire

// file: hw/par_regs.sv
// Negotiation status, transceiver event and control registers behind an AXI4-Lite slave.
`default_nettype none
// Function
// - Partner T4, fast full/half, ten full/half abilities read in bits 9 to 5.
// - Partner five-bit selector reads in bits 4 to 0; 00001 means IEEE 802.3.
// - Expansion bit 4 latches a parallel detection fault until the register is read.
// - Expansion bit 1 latches a newly received page until the register is read.
// - Own next-page ability reads zero in bit 2; partner's in bit 3.
// - Expansion bit 0 follows whether the partner can auto-negotiate.
// - Mode bit 11 selects reduced long-cable squelch; resets to zero.
// - Configuration bit 9 reads one for 100 Mb/s, zero for 10 Mb/s.
// - Configuration bit 8 reads one for full duplex, zero for half.
// - Configuration bit 7 reads whether pause flow control is enabled.
// - Status bit 6 latches negotiation completion, cleared by reading.
// - Status bit 5 latches a remote fault, cleared by reading.
// - Status bit 4 latches link down, cleared by reading.
// - Status bit 3 latches a received link code word, cleared by reading.
// - Status bit 2 latches a parallel detection fault, cleared by reading.
// - Status bit 1 latches a received negotiation page, cleared by reading.
// - Count receive error packets; at 64 latch status bit 0, cleared by reading.
// - Writable enables at bits 6 to 0 match the status bits; reset disabled.
// - Fast control bit 13 stops the receive error counter; resets clear.
// - Fast control bit 12 mirrors the basic negotiation-complete status.
// - A latched bit reads one once after its event, then clears.

module par_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              partner_t4_ability,
	input  wire logic              partner_fast_full_ability,
	input  wire logic              partner_fast_half_ability,
	input  wire logic              partner_ten_full_ability,
	input  wire logic              partner_ten_half_ability,
	input  wire logic [4:0]        partner_selector,
	input  wire logic              partner_next_page_ability,
	input  wire logic              partner_negotiation_capable,
	input  wire logic              parallel_detect_fault,
	input  wire logic              page_received,
	input  wire logic              speed_100,
	input  wire logic              full_duplex,
	input  wire logic              pause_enabled,
	input  wire logic              negotiation_complete,
	input  wire logic              negotiation_done_evt,
	input  wire logic              remote_fault_evt,
	input  wire logic              link_down_evt,
	input  wire logic              ack_received_evt,
	input  wire logic              rx_error_packet,
	output logic                   long_cable_squelch,
	output logic                   transceiver_irq
);

	// ==========================================================================
	// Register bus: write channel
	// ==========================================================================
	// Address and data are held separately so that either may arrive first.
	logic              aw_have;
	logic              w_have;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;

	wire aw_take    = s_axi_awvalid && s_axi_awready;
	wire w_take     = s_axi_wvalid && s_axi_wready;
	wire do_write   = aw_have && w_have;
	wire next_aw_have = do_write ? 1'b0 : (aw_have || aw_take);
	wire next_w_have  = do_write ? 1'b0 : (w_have || w_take);
	wire next_bvalid  = do_write ? 1'b1 : (s_axi_bvalid && !s_axi_bready);
	wire next_awready = !next_aw_have && !next_bvalid;
	wire next_wready  = !next_w_have && !next_bvalid;

	wire [7:0] wr_ofs = {aw_addr_q[7:2], 2'h0};
	wire wr_mode      = do_write && (wr_ofs == par_pkg::OFS_MODE_CONTROL);
	wire wr_enable    = do_write && (wr_ofs == par_pkg::OFS_IRQ_ENABLE);
	wire wr_fast      = do_write && (wr_ofs == par_pkg::OFS_FAST_TX_CONTROL);

	// ==========================================================================
	// Register bus: read channel
	// ==========================================================================
	wire       ar_take     = s_axi_arvalid && s_axi_arready;
	wire       next_rvalid = ar_take ? 1'b1 : (s_axi_rvalid && !s_axi_rready);
	wire       next_arready = !next_rvalid;
	wire [7:0] rd_ofs      = {s_axi_araddr[7:2], 2'h0};
	wire       rd_partner  = (rd_ofs == par_pkg::OFS_PARTNER_ABILITY);
	wire       rd_expand   = (rd_ofs == par_pkg::OFS_EXPANSION);
	wire       rd_modectl  = (rd_ofs == par_pkg::OFS_MODE_CONTROL);
	wire       rd_config   = (rd_ofs == par_pkg::OFS_CONFIG_STATUS);
	wire       rd_enable   = (rd_ofs == par_pkg::OFS_IRQ_ENABLE);
	wire       rd_fast     = (rd_ofs == par_pkg::OFS_FAST_TX_CONTROL);
	wire       rd_mapped   = rd_partner || rd_expand || rd_modectl
		|| rd_config || rd_enable || rd_fast;
	wire       clr_expand  = ar_take && rd_expand;
	wire       clr_status  = ar_take && rd_config;

	// ==========================================================================
	// Control registers
	// ==========================================================================
	logic [par_pkg::IRQ_W-1:0] irq_enable;
	logic                      rx_error_counter_off;

	wire next_squelch = (wr_mode && wstrb_q[1]) ? wdata_q[par_pkg::BIT_LONG_SQUELCH]
		: long_cable_squelch;
	wire [par_pkg::IRQ_W-1:0] next_irq_enable = (wr_enable && wstrb_q[0])
		? wdata_q[par_pkg::IRQ_W-1:0] : irq_enable;
	wire next_counter_off = (wr_fast && wstrb_q[1]) ? wdata_q[par_pkg::BIT_RXERR_OFF]
		: rx_error_counter_off;

	// ==========================================================================
	// Receive error counter
	// ==========================================================================
	// The count restarts after each full mark so a steady error stream keeps
	// re-raising the event rather than leaving it pinned high.
	logic [6:0] rx_error_count;

	wire rx_count_step = rx_error_packet && !rx_error_counter_off;
	wire rx_error_full = rx_count_step
		&& (rx_error_count == 7'(par_pkg::RX_ERR_LIMIT - 1));
	wire [6:0] next_rx_error_count = !rx_count_step ? rx_error_count
		: (rx_error_full ? 7'h00 : rx_error_count + 7'h01);

	// ==========================================================================
	// Latched event flags
	// ==========================================================================
	logic                      exp_parallel_fault;
	logic                      page_received_flag;
	logic [par_pkg::IRQ_W-1:0] irq_status;
	logic [par_pkg::IRQ_W-1:0] irq_events;
	logic [par_pkg::IRQ_W-1:0] next_irq_status;

	// A new event wins over the clear of the same read.
	wire next_exp_pdf  = (exp_parallel_fault && !clr_expand) || parallel_detect_fault;
	wire next_exp_page = (page_received_flag && !clr_expand) || page_received;

	assign irq_events[par_pkg::BIT_IRQ_ANC]    = negotiation_done_evt;
	assign irq_events[par_pkg::BIT_IRQ_RFAULT] = remote_fault_evt;
	assign irq_events[par_pkg::BIT_IRQ_LINK]   = link_down_evt;
	assign irq_events[par_pkg::BIT_IRQ_ACK]    = ack_received_evt;
	assign irq_events[par_pkg::BIT_IRQ_PDF]    = parallel_detect_fault;
	assign irq_events[par_pkg::BIT_IRQ_PAGE]   = page_received;
	assign irq_events[par_pkg::BIT_IRQ_RXERR]  = rx_error_full;

	genvar gi;
	generate
		for (gi = 0; gi < par_pkg::IRQ_W; gi = gi + 1)
		begin : g_latch
			assign next_irq_status[gi] = (irq_status[gi] && !clr_status)
				|| irq_events[gi];
		end
	endgenerate

	wire next_irq = |(next_irq_status & next_irq_enable);

	// ==========================================================================
	// Read data selection
	// ==========================================================================
	wire [15:0] val_partner = {6'h00,
		partner_t4_ability, partner_fast_full_ability, partner_fast_half_ability,
		partner_ten_full_ability, partner_ten_half_ability,
		partner_selector};
	wire [15:0] val_expand = {11'h000, exp_parallel_fault, partner_next_page_ability,
		1'b0, page_received_flag, partner_negotiation_capable};
	wire [15:0] val_modectl = {4'h0, long_cable_squelch, 11'h000};
	wire [15:0] val_config = {6'h00, speed_100, full_duplex, pause_enabled,
		irq_status};
	wire [15:0] val_enable = {9'h000, irq_enable};
	wire [15:0] val_fast = {2'h0, rx_error_counter_off, negotiation_complete,
		12'h000};
	wire [15:0] rd_value = rd_partner ? val_partner
		: rd_expand ? val_expand
		: rd_modectl ? val_modectl
		: rd_config ? val_config
		: rd_enable ? val_enable
		: rd_fast ? val_fast
		: 16'h0000;
	wire [1:0] rd_resp = rd_mapped ? par_pkg::RESP_OKAY : par_pkg::RESP_SLVERR;

	wire wr_mapped = (wr_ofs == par_pkg::OFS_PARTNER_ABILITY)
		|| (wr_ofs == par_pkg::OFS_EXPANSION)
		|| (wr_ofs == par_pkg::OFS_MODE_CONTROL)
		|| (wr_ofs == par_pkg::OFS_CONFIG_STATUS)
		|| (wr_ofs == par_pkg::OFS_IRQ_ENABLE)
		|| (wr_ofs == par_pkg::OFS_FAST_TX_CONTROL);
	wire [1:0] wr_resp = wr_mapped ? par_pkg::RESP_OKAY : par_pkg::RESP_SLVERR;

	// ==========================================================================
	// Bus handshake registers
	// ==========================================================================
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= par_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= par_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
		end
		else
		begin
			aw_have       <= next_aw_have;
			w_have        <= next_w_have;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			if (do_write)
			begin
				s_axi_bresp <= wr_resp;
			end
			if (ar_take)
			begin
				s_axi_rdata <= {16'h0000, rd_value};
				s_axi_rresp <= rd_resp;
			end
		end
	end

	// Payload holders carry no control meaning, so they need no reset.
	always_ff @(posedge aclk)
	begin
		if (aw_take)
		begin
			aw_addr_q <= s_axi_awaddr;
		end
		if (w_take)
		begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// ==========================================================================
	// Block state registers
	// ==========================================================================
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			long_cable_squelch   <= par_pkg::RST_SQUELCH;
			irq_enable           <= par_pkg::RST_IRQ_ENABLE;
			rx_error_counter_off <= par_pkg::RST_RXERR_OFF;
			rx_error_count       <= 7'h00;
			exp_parallel_fault   <= 1'b0;
			page_received_flag   <= 1'b0;
			irq_status           <= 7'h00;
			transceiver_irq      <= 1'b0;
		end
		else
		begin
			long_cable_squelch   <= next_squelch;
			irq_enable           <= next_irq_enable;
			rx_error_counter_off <= next_counter_off;
			rx_error_count       <= next_rx_error_count;
			exp_parallel_fault   <= next_exp_pdf;
			page_received_flag   <= next_exp_page;
			irq_status           <= next_irq_status;
			transceiver_irq      <= next_irq;
		end
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	a_pdf_expansion_latch:
		assert property (@(posedge aclk) disable iff (!aresetn)
			parallel_detect_fault |=> exp_parallel_fault ##1 exp_parallel_fault
				|| (s_axi_rvalid && s_axi_rdata[par_pkg::BIT_EXP_PDF]))
		else $error("Parallel fault flag did not hold after its event.");

	a_page_flag_clear:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(clr_expand && page_received_flag && !page_received)
				|=> !page_received_flag && s_axi_rdata[par_pkg::BIT_EXP_PAGE])
		else $error("Page flag was not returned and cleared by its read.");

	a_own_np_zero:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(ar_take && rd_expand) |=> !s_axi_rdata[par_pkg::BIT_EXP_OWN_NP]
				&& s_axi_rvalid)
		else $error("Own next-page bit read as one.");

	a_squelch_write:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(wr_mode && wstrb_q[1])
				|=> long_cable_squelch == $past(wdata_q[par_pkg::BIT_LONG_SQUELCH]))
		else $error("Squelch select did not follow its write.");

	a_speed_report:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(ar_take && rd_config)
				|=> s_axi_rdata[par_pkg::BIT_SPEED] == $past(speed_100)
				&& s_axi_rdata[par_pkg::BIT_DUPLEX] == $past(full_duplex))
		else $error("Speed or duplex read back wrong.");

	a_anc_latch:
		assert property (@(posedge aclk) disable iff (!aresetn)
			negotiation_done_evt |=> irq_status[par_pkg::BIT_IRQ_ANC])
		else $error("Negotiation complete event was not latched.");

	a_rxerr_full:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(rx_count_step && rx_error_count == 7'h3F)
				|=> irq_status[par_pkg::BIT_IRQ_RXERR] && rx_error_count == 7'h00)
		else $error("Receive error count did not flag at sixty-four.");

	a_counter_frozen:
		assert property (@(posedge aclk) disable iff (!aresetn)
			rx_error_counter_off |=> $stable(rx_error_count))
		else $error("Receive error counter moved while stopped.");

	a_read_clears:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(clr_status && irq_status[par_pkg::BIT_IRQ_LINK] && !link_down_evt)
				|=> s_axi_rdata[par_pkg::BIT_IRQ_LINK]
				&& !irq_status[par_pkg::BIT_IRQ_LINK])
		else $error("Link fail flag was not returned then cleared.");

	a_fast_anc_mirror:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(ar_take && rd_fast)
				|=> s_axi_rdata[par_pkg::BIT_FAST_ANC] == $past(negotiation_complete))
		else $error("Fast control did not mirror negotiation complete.");

	a_irq_gating:
		assert property (@(posedge aclk) disable iff (!aresetn)
			##1 transceiver_irq == (|(irq_status & irq_enable)))
		else $error("Interrupt request disagrees with flags and enables.");

	a_enable_write:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(wr_enable && wstrb_q[0])
				|=> irq_enable == $past(wdata_q[par_pkg::IRQ_W-1:0]))
		else $error("Event enables did not follow their write.");

	a_partner_an_live:
		assert property (@(posedge aclk) disable iff (!aresetn)
			(ar_take && rd_expand)
				|=> s_axi_rdata[par_pkg::BIT_EXP_PARTNER_AN]
					== $past(partner_negotiation_capable)
				&& s_axi_rdata[par_pkg::BIT_EXP_PARTNER_NP]
					== $past(partner_next_page_ability))
		else $error("Partner negotiation abilities read back wrong.");

	a_rfault_latch:
		assert property (@(posedge aclk) disable iff (!aresetn)
			remote_fault_evt |=> irq_status[par_pkg::BIT_IRQ_RFAULT])
		else $error("Remote fault event was not latched.");

	a_link_latch:
		assert property (@(posedge aclk) disable iff (!aresetn)
			link_down_evt |=> irq_status[par_pkg::BIT_IRQ_LINK])
		else $error("Link down event was not latched.");

	a_page_status_latch:
		assert property (@(posedge aclk) disable iff (!aresetn)
			page_received |=> irq_status[par_pkg::BIT_IRQ_PAGE]
				&& page_received_flag)
		else $error("Received page was not latched in both registers.");

endmodule : par_regs

`default_nettype wire

// file: sim/par_partner.sv
// Model of the remote link partner and line state that feed the negotiation registers.
`default_nettype none
module par_partner (
	input  wire logic aclk,
	output logic [9:0] ability,
	output logic [1:0] np_an,
	output logic [3:0] cfg,
	output logic [6:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// Line state
	// ==========================================================================
	// Levels change right after an edge so the block never samples them mid-change.
	initial
	begin
		ability = 10'h000;
		np_an = 2'h0;
		cfg = 4'h0;
		ev = 7'h00;
	end
	task set_lines(input logic [9:0] a, input logic [1:0] n, input logic [3:0] c);
		@(posedge aclk);
		ability <= a;
		np_an <= n;
		cfg <= c;
	endtask : set_lines
	// ==========================================================================
	// Events
	// ==========================================================================
	// An event stays high n cycles; on the error line that counts n packets.
	task pulse(input int idx, input int n);
		@(posedge aclk);
		ev[idx] <= 1'b1;
		repeat (n) @(posedge aclk);
		ev[idx] <= 1'b0;
	endtask : pulse
endmodule : par_partner
`default_nettype wire

// file: sim/par_regs_tb.sv
// Self-checking bench for the negotiation status and event registers.
`default_nettype none
module par_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic long_cable_squelch, transceiver_irq;
	logic [9:0] ability;
	logic [1:0] np_an;
	logic [3:0] cfg;
	logic [6:0] ev;
	int n_errors = 0;
	int checks = 0;
	int i;
	always #20 aclk = ~aclk;
	par_partner par_partner_inst (.aclk, .ability, .np_an, .cfg, .ev);
	par_regs par_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .partner_t4_ability(ability[9]),
		.partner_fast_full_ability(ability[8]), .partner_fast_half_ability(ability[7]),
		.partner_ten_full_ability(ability[6]), .partner_ten_half_ability(ability[5]),
		.partner_selector(ability[4:0]), .partner_next_page_ability(np_an[1]),
		.partner_negotiation_capable(np_an[0]), .parallel_detect_fault(ev[2]),
		.page_received(ev[1]), .speed_100(cfg[3]), .full_duplex(cfg[2]),
		.pause_enabled(cfg[1]), .negotiation_complete(cfg[0]), .negotiation_done_evt(ev[6]),
		.remote_fault_evt(ev[5]), .link_down_evt(ev[4]), .ack_received_evt(ev[3]),
		.rx_error_packet(ev[0]), .long_cable_squelch, .transceiver_irq);
	// ==========================================================================
	// Checking and closing
	// ==========================================================================
	task close_out;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
			n_errors++;
		end
	endtask : chk
	// A wait that runs out its bound ends the run rather than hanging it.
	task stuck(input int k);
		if (k >= 50)
		begin
			$display("BAD %0t no handshake", $time);
			n_errors++;
			close_out();
		end
	endtask : stuck
	// ==========================================================================
	// Bus cycles
	// ==========================================================================
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int k;
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		for (k = 0; k < 50 && !(aw_ok && w_ok); k++)
		begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		stuck(k);
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_bvalid)
				break;
		end
		stuck(k);
		chk(s_axi_bresp, er, "write response");
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				break;
		end
		stuck(k);
		s_axi_arvalid <= 1'b0;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			if (s_axi_rvalid)
				break;
		end
		stuck(k);
		chk(s_axi_rdata, ed, "read data");
		chk(s_axi_rresp, er, "read response");
		s_axi_rready <= 1'b0;
	endtask : rd
	// ==========================================================================
	// Tests
	// ==========================================================================
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(par_pkg::OFS_IRQ_ENABLE, 32'h0, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_MODE_CONTROL, 32'h0, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_FAST_TX_CONTROL, 32'h0, par_pkg::RESP_OKAY);
		chk(long_cable_squelch, 1'b0, "squelch after reset");
		$display("test reset done");
		for (i = 0; i < 3; i++)
		begin
			par_partner_inst.set_lines(10'h3E1 - 10'h0C5 * i, 2'h3 - i, 4'hA + 4'h5 * i);
			@(posedge aclk);
			rd(par_pkg::OFS_PARTNER_ABILITY, {22'h0, ability}, 2'h0);
			rd(par_pkg::OFS_EXPANSION, {28'h0, np_an[1], 2'h0, np_an[0]}, 2'h0);
			rd(par_pkg::OFS_CONFIG_STATUS, {22'h0, cfg[3:1], 7'h0}, 2'h0);
			rd(par_pkg::OFS_FAST_TX_CONTROL, {19'h0, cfg[0], 12'h0}, 2'h0);
		end
		par_partner_inst.set_lines(10'h3E1, 2'h3, 4'hF);
		axi_wr(par_pkg::OFS_PARTNER_ABILITY, 32'hFFFF, 4'hF, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_PARTNER_ABILITY, 32'h3E1, par_pkg::RESP_OKAY);
		axi_wr(8'hE0, 32'hFFFF, 4'hF, par_pkg::RESP_SLVERR);
		rd(8'hE0, 32'h0, par_pkg::RESP_SLVERR);
		$display("test static fields done");
		for (i = 1; i < 7; i++)
		begin
			par_partner_inst.pulse(i, 1);
			rd(par_pkg::OFS_CONFIG_STATUS, 32'h380 | (32'h1 << i),
				2'h0);
			rd(par_pkg::OFS_CONFIG_STATUS, 32'h380, 2'h0);
			rd(par_pkg::OFS_EXPANSION,
				32'h9 | (i == 2 ? 32'h10 : i == 1 ? 32'h2 : 32'h0), 2'h0);
			rd(par_pkg::OFS_EXPANSION, 32'h9, 2'h0);
		end
		$display("test events done");
		par_partner_inst.pulse(0, 63);
		rd(par_pkg::OFS_CONFIG_STATUS, 32'h380, 2'h0);
		par_partner_inst.pulse(0, 1);
		rd(par_pkg::OFS_CONFIG_STATUS, 32'h381, 2'h0);
		axi_wr(par_pkg::OFS_FAST_TX_CONTROL, 32'h2000, 4'hF, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_FAST_TX_CONTROL, 32'h3000, 2'h0);
		par_partner_inst.pulse(0, 64);
		rd(par_pkg::OFS_CONFIG_STATUS, 32'h380, 2'h0);
		axi_wr(par_pkg::OFS_FAST_TX_CONTROL, 32'h0, 4'hF, par_pkg::RESP_OKAY);
		$display("test error counter done");
		axi_wr(par_pkg::OFS_IRQ_ENABLE, 32'h7F, 4'hF, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_IRQ_ENABLE, 32'h7F, 2'h0);
		axi_wr(par_pkg::OFS_IRQ_ENABLE, 32'h20, 4'hF, par_pkg::RESP_OKAY);
		par_partner_inst.pulse(4, 1);
		repeat (2) @(posedge aclk);
		chk(transceiver_irq, 1'b0, "masked event raised request");
		par_partner_inst.pulse(5, 1);
		repeat (2) @(posedge aclk);
		chk(transceiver_irq, 1'b1, "enabled event missing");
		rd(par_pkg::OFS_CONFIG_STATUS, 32'h3B0, 2'h0);
		@(posedge aclk);
		chk(transceiver_irq, 1'b0, "request after clear");
		$display("test request done");
		axi_wr(par_pkg::OFS_MODE_CONTROL, 32'h800, 4'h1, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_MODE_CONTROL, 32'h0, 2'h0);
		axi_wr(par_pkg::OFS_MODE_CONTROL, 32'h800, 4'h2, par_pkg::RESP_OKAY);
		rd(par_pkg::OFS_MODE_CONTROL, 32'h800, 2'h0);
		chk(long_cable_squelch, 1'b1, "squelch set");
		axi_wr(par_pkg::OFS_MODE_CONTROL, 32'h0, 4'hF, par_pkg::RESP_OKAY);
		chk(long_cable_squelch, 1'b0, "squelch clear");
		$display("test squelch done");
		close_out();
	end
endmodule : par_regs_tb
`default_nettype wire
